// file: core/test_link_regs.svh
// Message codes, status flag bits and payload layout of the test link responder.
`ifndef TEST_LINK_REGS_SVH
`define TEST_LINK_REGS_SVH

`define CODE_VOL_UP          8'h33
`define CODE_VOL_DOWN        8'h34
`define CODE_STATUS_REQ      8'h35
`define CODE_INDICATION_REQ  8'h36
`define CODE_POWER_REQ       8'h37
`define CODE_BELL_REQ        8'h38
`define CODE_SM_REQ          8'h39
`define CODE_KEYSTROKES      8'h3A
`define CODE_HOOK_ON         8'h40
`define CODE_HOOK_OFF        8'h41
`define CODE_BEARER_SELECT   8'h46
`define CODE_SET_POWER       8'h50
`define CODE_STATUS_RSP      8'h5B
`define CODE_INDICATION_RSP  8'h5C
`define CODE_SM_RSP          8'h65
`define CODE_NO_SM_RSP       8'h66
`define CODE_FAULT_ERR       8'hF0
`define CODE_NOT_REC_ERR     8'hF1
`define CODE_NOT_PERF_ERR    8'hF2
`define CODE_RESTART         8'hFF

`define FLAG_SACCH_BIT       3
`define FLAG_TCH_BIT         2
`define FLAG_BCCH_BIT        1
`define FLAG_SDCCH_BIT       0
`define SPARE_STATUS         4'h0
`define SPARE_INDICATION     7'h00

`define SM_NULL_POS          8'h00
`define SM_OA_POS            8'h01
`define SM_SC_POS            8'h0D
`define SM_ADDR_LEN          4'hC
`define SM_UDL_POS           8'h22
`define SM_FIXED_LEN         8'h23
`define SM_UD_MAX            8'h8C
`define SM_DEPTH             175

`define LEN_ONE              8'h01
`define LEN_TWO              8'h02
`define NULL_BYTE            8'h00

`endif

// file: core/test_link_pkg.sv
// Types of the test link responder: states, answer kinds and the state record.
package test_link_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SKIP = 5'b00010,
    ST_LOAD = 5'b00100,
    ST_MEMW = 5'b01000,
    ST_WAIT = 5'b10000
  } state_e;

  typedef enum logic [6:0] {
    K_STATUS   = 7'b0000001,
    K_INDICATE = 7'b0000010,
    K_SM       = 7'b0000100,
    K_NO_SM    = 7'b0001000,
    K_FAULT    = 7'b0010000,
    K_NOT_REC  = 7'b0100000,
    K_NOT_PERF = 7'b1000000
  } kind_e;

  typedef struct packed {
    state_e     st;
    kind_e      kind;
    logic       go_load;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       tx_last;
    logic       rx_ready;
    logic [7:0] idx;
    logic [7:0] err_code;
    logic       fault_pend;
    logic [7:0] fault_code;
    logic       have_msg;
    logic [3:0] oa_len;
    logic [3:0] sc_len;
    logic [7:0] ud_len;
    logic       restart;
  } resp_state_s;

endpackage

// file: core/sm_mem_if.sv
// Read and write port between the responder and its short message store.
`timescale 1ns/1ps
interface sm_mem_if;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface

// file: core/sm_store_mem.sv
// Byte store for one short message payload with registered read data.
`timescale 1ns/1ps
`include "test_link_regs.svh"
module sm_store_mem #(
  parameter int DEPTH = `SM_DEPTH
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Access port
  sm_mem_if.mem     port
);

  logic [7:0] mem [DEPTH];
  logic [7:0] rd_data_r;

  // Contents are not reset; the responder only uses read data after a store is flagged.
  always_ff @(posedge clk)
  begin
    if (port.wr_en && (int'(port.wr_addr) < DEPTH))
    begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_r <= 8'h00;
    end
    else if (port.rd_en)
    begin
      rd_data_r <= (int'(port.rd_addr) < DEPTH) ? mem[port.rd_addr] : 8'h00;
    end
  end

  assign port.rd_data = rd_data_r;

endmodule // sm_store_mem

// file: core/test_link_responder.sv
// Layer-3 answer engine of the test link: decodes requests and streams replies.
`timescale 1ns/1ps
`include "test_link_regs.svh"
module test_link_responder #(
  parameter int SM_DEPTH = `SM_DEPTH
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Octets arriving from the simulator
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_last,
  output logic            rx_ready,
  // Octets going to the simulator
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            tx_last,
  input  wire logic       tx_ready,
  // Channel state from the station
  input  wire logic       sacch_up,
  input  wire logic       tch_up,
  input  wire logic       bcch_listen,
  input  wire logic       sdcch_up,
  input  wire logic       service_on,
  // Short message store loading
  input  wire logic       sm_wr_en,
  input  wire logic [7:0] sm_wr_addr,
  input  wire logic [7:0] sm_wr_data,
  input  wire logic       sm_store,
  input  wire logic [3:0] sm_oa_len,
  input  wire logic [3:0] sm_sc_len,
  input  wire logic [7:0] sm_ud_len,
  // Internal fault report
  input  wire logic       fault_valid,
  input  wire logic [7:0] fault_code,
  // Restart request to the rest of the station
  output logic            restart
);

  localparam int FULL_SM = int'(`SM_FIXED_LEN) + int'(`SM_UD_MAX);

  generate
    if (SM_DEPTH < FULL_SM || SM_DEPTH > 255)
    begin : g_depth_check
      $error("SM_DEPTH must hold a full payload and stay below 256");
    end
  endgenerate

  localparam test_link_pkg::resp_state_s RESET_S = '{
    st:         test_link_pkg::ST_IDLE,
    kind:       test_link_pkg::K_NOT_REC,
    go_load:    1'b0,
    tx_valid:   1'b0,
    tx_data:    8'h00,
    tx_last:    1'b0,
    rx_ready:   1'b1,
    idx:        8'h00,
    err_code:   8'h00,
    fault_pend: 1'b0,
    fault_code: 8'h00,
    have_msg:   1'b0,
    oa_len:     4'h0,
    sc_len:     4'h0,
    ud_len:     8'h00,
    restart:    1'b0
  };

  test_link_pkg::resp_state_s s_r;
  test_link_pkg::resp_state_s s_nxt;

  sm_mem_if mem_bus ();

  sm_store_mem #(
    .DEPTH (SM_DEPTH)
  ) u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .port  (mem_bus.mem)
  );

  assign mem_bus.wr_en   = sm_wr_en;
  assign mem_bus.wr_addr = sm_wr_addr;
  assign mem_bus.wr_data = sm_wr_data;
  // Payload byte p sits at store address p, one behind the octet index.
  assign mem_bus.rd_en   = (s_r.st == test_link_pkg::ST_LOAD);
  assign mem_bus.rd_addr = s_r.idx - `LEN_ONE;

  logic [7:0] msg_len;
  logic [7:0] pos;
  logic [7:0] reply_byte;
  logic [3:0] flags;

  // Number of octets in the answer being sent.
  always_comb
  begin
    case (s_r.kind)
      test_link_pkg::K_STATUS,
      test_link_pkg::K_INDICATE,
      test_link_pkg::K_FAULT: msg_len = `LEN_TWO;
      test_link_pkg::K_SM:    msg_len = `LEN_ONE + `SM_FIXED_LEN + s_r.ud_len;
      default:                msg_len = `LEN_ONE;
    endcase
  end

  // Octet at the current index of the answer.
  always_comb
  begin
    pos = s_r.idx - `LEN_ONE;
    flags = 4'h0;
    flags[`FLAG_SACCH_BIT] = sacch_up;
    flags[`FLAG_TCH_BIT]   = tch_up;
    flags[`FLAG_BCCH_BIT]  = bcch_listen;
    flags[`FLAG_SDCCH_BIT] = sdcch_up;
    reply_byte = `NULL_BYTE;
    if (s_r.idx == 8'h00)
    begin
      case (s_r.kind)
        test_link_pkg::K_STATUS:   reply_byte = `CODE_STATUS_RSP;
        test_link_pkg::K_INDICATE: reply_byte = `CODE_INDICATION_RSP;
        test_link_pkg::K_SM:       reply_byte = `CODE_SM_RSP;
        test_link_pkg::K_NO_SM:    reply_byte = `CODE_NO_SM_RSP;
        test_link_pkg::K_FAULT:    reply_byte = `CODE_FAULT_ERR;
        test_link_pkg::K_NOT_PERF: reply_byte = `CODE_NOT_PERF_ERR;
        default:                   reply_byte = `CODE_NOT_REC_ERR;
      endcase
    end
    else
    begin
      case (s_r.kind)
        test_link_pkg::K_STATUS:   reply_byte = {`SPARE_STATUS, flags};
        test_link_pkg::K_INDICATE: reply_byte = {`SPARE_INDICATION, service_on};
        test_link_pkg::K_FAULT:    reply_byte = s_r.err_code;
        test_link_pkg::K_SM:
        begin
          reply_byte = mem_bus.rd_data;
          if (pos == `SM_NULL_POS)
          begin
            reply_byte = `NULL_BYTE;
          end
          else if (pos < `SM_SC_POS)
          begin
            if ((pos - `SM_OA_POS) >= {4'h0, s_r.oa_len})
            begin
              reply_byte = `NULL_BYTE;
            end
          end
          else if (pos < (`SM_SC_POS + {4'h0, `SM_ADDR_LEN}))
          begin
            if ((pos - `SM_SC_POS) >= {4'h0, s_r.sc_len})
            begin
              reply_byte = `NULL_BYTE;
            end
          end
          else if (pos == `SM_UDL_POS)
          begin
            reply_byte = s_r.ud_len;
          end
        end
        default:                   reply_byte = `NULL_BYTE;
      endcase
    end
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.restart = 1'b0;
    case (s_r.st)
      test_link_pkg::ST_IDLE:
      begin
        if (rx_valid)
        begin
          // Only the leading octet steers the answer; the rest is drained.
          s_nxt.go_load = 1'b1;
          case (rx_data)
            `CODE_STATUS_REQ:     s_nxt.kind = test_link_pkg::K_STATUS;
            `CODE_INDICATION_REQ: s_nxt.kind = test_link_pkg::K_INDICATE;
            `CODE_SM_REQ:         s_nxt.kind = s_r.have_msg ? test_link_pkg::K_SM
                                                           : test_link_pkg::K_NO_SM;
            `CODE_NOT_REC_ERR:    s_nxt.kind = s_r.kind;
            `CODE_VOL_UP,
            `CODE_VOL_DOWN,
            `CODE_POWER_REQ,
            `CODE_BELL_REQ,
            `CODE_KEYSTROKES,
            `CODE_HOOK_ON,
            `CODE_HOOK_OFF,
            `CODE_BEARER_SELECT,
            `CODE_SET_POWER:      s_nxt.kind = test_link_pkg::K_NOT_PERF;
            `CODE_RESTART:
            begin
              s_nxt = RESET_S;
              s_nxt.restart = 1'b1;
            end
            default:              s_nxt.kind = test_link_pkg::K_NOT_REC;
          endcase
          // A pending fault rides out on the next answer that is not a resend, never on its own.
          if (s_r.fault_pend && rx_data != `CODE_RESTART && rx_data != `CODE_NOT_REC_ERR)
          begin
            s_nxt.kind = test_link_pkg::K_FAULT;
            s_nxt.err_code = s_r.fault_code;
            s_nxt.fault_pend = 1'b0;
          end
          if (rx_data == `CODE_RESTART)
          begin
            s_nxt.go_load = 1'b0;
          end
          s_nxt.idx = 8'h00;
          if (!rx_last)
          begin
            s_nxt.st = test_link_pkg::ST_SKIP;
          end
          else if (s_nxt.go_load)
          begin
            s_nxt.st = test_link_pkg::ST_LOAD;
            s_nxt.rx_ready = 1'b0;
          end
        end
      end
      test_link_pkg::ST_SKIP:
      begin
        if (rx_valid && rx_last)
        begin
          if (s_r.go_load)
          begin
            s_nxt.st = test_link_pkg::ST_LOAD;
            s_nxt.rx_ready = 1'b0;
          end
          else
          begin
            s_nxt.st = test_link_pkg::ST_IDLE;
          end
        end
      end
      test_link_pkg::ST_LOAD:
      begin
        s_nxt.st = test_link_pkg::ST_MEMW;
      end
      test_link_pkg::ST_MEMW:
      begin
        s_nxt.tx_valid = 1'b1;
        s_nxt.tx_data = reply_byte;
        s_nxt.tx_last = (s_r.idx == msg_len - `LEN_ONE);
        s_nxt.st = test_link_pkg::ST_WAIT;
      end
      test_link_pkg::ST_WAIT:
      begin
        if (tx_ready)
        begin
          s_nxt.tx_valid = 1'b0;
          s_nxt.tx_last = 1'b0;
          if (s_r.tx_last)
          begin
            s_nxt.st = test_link_pkg::ST_IDLE;
            s_nxt.rx_ready = 1'b1;
          end
          else
          begin
            s_nxt.idx = s_r.idx + `LEN_ONE;
            s_nxt.st = test_link_pkg::ST_LOAD;
          end
        end
      end
      default:
      begin
        s_nxt = RESET_S;
      end
    endcase
    // Station events are applied last so that they win over any clear above.
    if (sm_store)
    begin
      s_nxt.have_msg = 1'b1;
      s_nxt.oa_len = (sm_oa_len > `SM_ADDR_LEN) ? `SM_ADDR_LEN : sm_oa_len;
      s_nxt.sc_len = (sm_sc_len > `SM_ADDR_LEN) ? `SM_ADDR_LEN : sm_sc_len;
      s_nxt.ud_len = (sm_ud_len > `SM_UD_MAX) ? `SM_UD_MAX : sm_ud_len;
    end
    if (fault_valid)
    begin
      s_nxt.fault_pend = 1'b1;
      s_nxt.fault_code = fault_code;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= RESET_S;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rx_ready = s_r.rx_ready;
  assign tx_valid = s_r.tx_valid;
  assign tx_data  = s_r.tx_data;
  assign tx_last  = s_r.tx_last;
  assign restart  = s_r.restart;

endmodule // test_link_responder

// file: testbench/test_link_properties.sv
// Port level timing and framing checks for the test link responder.
`timescale 1ns/1ps
`include "test_link_regs.svh"
module test_link_properties #(
  parameter int SM_DEPTH = `SM_DEPTH
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Receive side
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       rx_last,
  input wire logic       rx_ready,
  // Transmit side
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic       tx_ready,
  // Fault and restart
  input wire logic       fault_valid,
  input wire logic       restart
);
  logic       head_r;
  logic       begin_r;
  logic       flt_r;
  logic [7:0] code_r;
  logic [7:0] pos_r;
  logic [7:0] req_r;
  wire        take = rx_valid && rx_ready;
  wire        hs   = tx_valid && tx_ready;

  // A fault stays pending until the leading octet of its error answer has gone out or a restart clears it.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      head_r  <= 1'b1;
      begin_r <= 1'b1;
      flt_r   <= 1'b0;
      code_r  <= 8'h00;
      pos_r   <= 8'h00;
      req_r   <= 8'h00;
    end
    else
    begin
      if (take)
        head_r <= rx_last;
      // A resend request may legally repeat an earlier fault answer.
      if (take && head_r)
        req_r <= rx_data;
      if (hs)
      begin
        begin_r <= tx_last;
        pos_r   <= tx_last ? 8'h00 : pos_r + 8'h01;
        if (begin_r)
          code_r <= tx_data;
      end
      flt_r <= fault_valid || (flt_r && !(hs && begin_r && tx_data == `CODE_FAULT_ERR)
               && !(take && head_r && rx_data == `CODE_RESTART));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_restart_pulse: assert property (take && head_r && rx_last && rx_data == `CODE_RESTART
    |-> ##[1:3] restart) else $error("restart pulse missing");
  chk_restart_silent: assert property (restart |=> !restart && !tx_valid)
    else $error("restart not a lone silent pulse");
  chk_answer_time: assert property (take && head_r && rx_last && rx_data != `CODE_RESTART
    |-> ##3 tx_valid) else $error("answer not on time");
  chk_status_code: assert property (take && head_r && rx_last
    && rx_data == `CODE_STATUS_REQ && !flt_r && !fault_valid
    |-> ##3 (tx_valid && tx_data == `CODE_STATUS_RSP && !tx_last)) else $error("status code wrong");
  chk_status_spare: assert property (tx_valid && !begin_r && code_r == `CODE_STATUS_RSP
    |-> tx_data[7:4] == `SPARE_STATUS && tx_last) else $error("status spare wrong");
  chk_single_octet: assert property (tx_valid && begin_r
    && tx_data inside {`CODE_NO_SM_RSP, `CODE_NOT_REC_ERR, `CODE_NOT_PERF_ERR}
    |-> tx_last) else $error("one octet answer too long");
  chk_fault_solicited: assert property (tx_valid && begin_r && tx_data == `CODE_FAULT_ERR
    |-> (flt_r || req_r == `CODE_NOT_REC_ERR) && !tx_last) else $error("fault answer without fault");
  chk_sm_null: assert property (tx_valid && !begin_r && code_r == `CODE_SM_RSP && pos_r == 8'h01
    |-> tx_data == `NULL_BYTE) else $error("payload does not open with null");
  chk_tx_hold: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("octet dropped early");
  chk_idle_quiet: assert property (tx_valid |-> !rx_ready)
    else $error("output while accepting");
  chk_ready_back: assert property (hs && tx_last |=> rx_ready && !tx_valid)
    else $error("receiver not reopened");
endmodule // test_link_properties

bind test_link_responder test_link_properties #(.SM_DEPTH(SM_DEPTH)) u_props (
  .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .fault_valid(fault_valid), .restart(restart)
);

// file: testbench/sim_link_sink.sv
// Simulator side sink that takes answers from the test link responder.
`timescale 1ns/1ps
module sim_link_sink (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Answer stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // Pacing
  input  wire logic       slow
);
  logic [7:0] got[$];
  int         n_msg;

  initial
  begin
    tx_ready = 1'b0;
    n_msg    = 0;
  end

  // A slow sink refuses every other cycle, so each octet must stand across a refusal.
  always @(posedge clk)
  begin
    if (rst_n && tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
      if (tx_last)
        n_msg++;
    end
    #1 tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule // sim_link_sink

// file: testbench/test_link_responder_tb.sv
// Self-checking bench for the test link responder.
`timescale 1ns/1ps
`include "test_link_regs.svh"
module test_link_responder_tb;
  logic       clk, rst_n, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, restart;
  logic       sacch_up, tch_up, bcch_listen, sdcch_up, service_on, slow;
  logic       sm_wr_en, sm_store, fault_valid;
  logic [7:0] rx_data, tx_data, sm_wr_addr, sm_wr_data, sm_ud_len, fault_code;
  logic [3:0] sm_oa_len, sm_sc_len;
  logic [7:0] exp_q[$];
  int         n_mismatch, checks, n_rst;

  test_link_responder #(.SM_DEPTH(175)) uut (
    .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .sacch_up(sacch_up), .tch_up(tch_up), .bcch_listen(bcch_listen),
    .sdcch_up(sdcch_up), .service_on(service_on), .sm_wr_en(sm_wr_en),
    .sm_wr_addr(sm_wr_addr), .sm_wr_data(sm_wr_data), .sm_store(sm_store),
    .sm_oa_len(sm_oa_len), .sm_sc_len(sm_sc_len), .sm_ud_len(sm_ud_len),
    .fault_valid(fault_valid), .fault_code(fault_code), .restart(restart));
  sim_link_sink sink (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow));

  always #5 clk = ~clk;
  always @(posedge clk) if (restart === 1'b1) n_rst++;

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic l);
    int i;
    rx_valid = 1'b1;
    rx_data  = b;
    rx_last  = l;
    // Ready is looked at off the edge, where it already shows what the next edge sees.
    for (i = 0; i < 100 && rx_ready !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i == 100)
    begin
      n_mismatch++;
      summarize();
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
  endtask

  // Sends a one-octet request and compares the whole answer with exp_q.
  task automatic ask(input logic [7:0] code);
    int i, n0;
    sink.got.delete();
    n0 = sink.n_msg;
    put(code, 1'b1);
    for (i = 0; i < 3000 && sink.n_msg == n0; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (sink.n_msg == n0)
    begin
      n_mismatch++;
      summarize();
    end
    cmp(8'(sink.got.size()), 8'(exp_q.size()));
    foreach (exp_q[k])
      cmp(sink.got[k], exp_q[k]);
    exp_q.delete();
  endtask

  task automatic t_status;
    {sacch_up, tch_up, bcch_listen, sdcch_up} = 4'hA;
    exp_q = '{`CODE_STATUS_RSP, 8'h0A};
    ask(`CODE_STATUS_REQ);
    {sacch_up, tch_up, bcch_listen, sdcch_up} = 4'h5;
    exp_q = '{`CODE_STATUS_RSP, 8'h05};
    ask(`CODE_NOT_REC_ERR);
    service_on = 1'b1;
    exp_q = '{`CODE_INDICATION_RSP, 8'h01};
    ask(`CODE_INDICATION_REQ);
  endtask

  task automatic t_sm;
    int p;
    exp_q = '{`CODE_NO_SM_RSP};
    ask(`CODE_SM_REQ);
    sm_wr_en = 1'b1;
    for (p = 0; p < 37; p++)
    begin
      sm_wr_addr = 8'(p);
      sm_wr_data = (p == 34) ? 8'h02 : 8'(p) + 8'h80;
      @(posedge clk);
      #1;
    end
    sm_wr_en  = 1'b0;
    sm_oa_len = 4'h3;
    sm_sc_len = 4'hC;
    sm_ud_len = 8'h02;
    sm_store  = 1'b1;
    @(posedge clk);
    #1;
    sm_store = 1'b0;
    exp_q = '{`CODE_SM_RSP};
    for (p = 0; p < 37; p++)
      exp_q.push_back((p == 0 || (p > 3 && p < 13)) ? `NULL_BYTE
                      : (p == 34) ? 8'h02 : 8'(p) + 8'h80);
    slow = 1'b1;
    ask(`CODE_SM_REQ);
    slow = 1'b0;
    // Short centre address and a length byte that differs from the stored byte.
    sm_oa_len = 4'hC;
    sm_sc_len = 4'h2;
    sm_ud_len = 8'h01;
    sm_store  = 1'b1;
    @(posedge clk);
    #1;
    sm_store = 1'b0;
    exp_q = '{`CODE_SM_RSP};
    for (p = 0; p < 36; p++)
      exp_q.push_back((p == 0 || (p > 14 && p < 25)) ? `NULL_BYTE
                      : (p == 34) ? 8'h01 : 8'(p) + 8'h80);
    ask(`CODE_SM_REQ);
  endtask

  task automatic t_errors;
    logic [7:0] unsup[9] = '{8'h33, 8'h34, 8'h37, 8'h38, 8'h3A, 8'h40, 8'h41, 8'h46, 8'h50};
    logic [7:0] unk[4]   = '{8'h00, 8'h3C, 8'hB4, 8'hF3};
    foreach (unsup[k])
    begin
      exp_q = '{`CODE_NOT_PERF_ERR};
      ask(unsup[k]);
    end
    foreach (unk[k])
    begin
      exp_q = '{`CODE_NOT_REC_ERR};
      ask(unk[k]);
    end
    // The simulator side frames an unintelligible message; the body octet must be ignored.
    put(8'h3C, 1'b0);
    @(posedge clk);
    #1;
    exp_q = '{`CODE_NOT_REC_ERR};
    ask(`CODE_STATUS_REQ);
  endtask

  task automatic t_fault;
    sink.got.delete();
    fault_code  = 8'h5A;
    fault_valid = 1'b1;
    @(posedge clk);
    #1;
    fault_valid = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    cmp(8'(sink.got.size()), 8'h00);
    exp_q = '{`CODE_FAULT_ERR, 8'h5A};
    ask(`CODE_STATUS_REQ);
    exp_q = '{`CODE_FAULT_ERR, 8'h5A};
    ask(`CODE_NOT_REC_ERR);
    exp_q = '{`CODE_STATUS_RSP, 8'h05};
    ask(`CODE_STATUS_REQ);
  endtask

  task automatic t_restart;
    sink.got.delete();
    n_rst = 0;
    put(`CODE_RESTART, 1'b1);
    repeat (10) @(posedge clk);
    #1;
    cmp(8'(n_rst), 8'h01);
    cmp(8'(sink.got.size()), 8'h00);
    exp_q = '{`CODE_NOT_REC_ERR};
    ask(`CODE_NOT_REC_ERR);
    exp_q = '{`CODE_NO_SM_RSP};
    ask(`CODE_SM_REQ);
  endtask

  initial
  begin
    clk   = 1'b0;
    rst_n = 1'b0;
    {rx_valid, rx_last, sm_wr_en, sm_store, fault_valid, slow, service_on} = '0;
    {sacch_up, tch_up, bcch_listen, sdcch_up} = 4'h0;
    {rx_data, sm_wr_addr, sm_wr_data, sm_ud_len, fault_code, sm_oa_len, sm_sc_len} = '0;
    n_mismatch = 0;
    checks     = 0;
    n_rst      = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_status();
    t_sm();
    t_errors();
    t_fault();
    t_restart();
    summarize();
  end
endmodule // test_link_responder_tb
